// *** dv/ground_station_model.sv ***
// Ground side model: downlink line decoder and uplink command sender
`timescale 1ns/1ps
module ground_station_model #(
	parameter int BIT_CYC = 16
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic tx_data_i,
	input  wire logic tx_stb_i,
	input  wire logic fs_i,
	output logic      cmd_data_o,
	output logic      dec_bit_o,
	output logic      dec_stb_o,
	output logic      dec_fs_o
);
	logic last_r;
	initial cmd_data_o = 1'b0;
	// A level change is a one, a held level a zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			last_r    <= 1'b0;
			dec_bit_o <= 1'b0;
			dec_stb_o <= 1'b0;
			dec_fs_o  <= 1'b0;
		end else begin
			dec_stb_o <= tx_stb_i;
			dec_fs_o  <= fs_i;
			if (tx_stb_i) begin
				dec_bit_o <= tx_data_i ^ last_r;
				last_r    <= tx_data_i;
			end
		end
	end
	// Plain level per bit, a whole bit period each, changed off the sampling edge
	task automatic send_bit(input logic b);
		@(negedge clk_i);
		cmd_data_o = b;
		repeat (BIT_CYC - 1) @(negedge clk_i);
	endtask : send_bit
	// Remainder register of x^7+x^6+x^2+1, the x^7 term implied
	function automatic logic [6:0] parity(input logic [55:0] d);
		logic [6:0] r;
		r = '0;
		for (int i = 55; i >= 0; i--)
			r = {r[5:0], 1'b0} ^ ((d[i] ^ r[6]) ? 7'h45 : 7'h00);
		return r;
	endfunction : parity
	// Fault 0 sends a good block and tail, 1 a flipped parity bit, 2 a set fill bit
	task automatic send_cltu(input logic [55:0] d, input int fault, input logic acq_one);
		logic [63:0] blk;
		blk = {d, ~parity(d), 1'b0};
		if (fault == 1)
			blk[1] = ~blk[1];
		if (fault == 2)
			blk[0] = 1'b1;
		for (int i = 0; i < 144; i++)
			send_bit(acq_one ^ i[0]);
		for (int i = 15; i >= 0; i--)
			send_bit(link_pkg::CLTU_START[i]);
		for (int i = 63; i >= 0; i--)
			send_bit(blk[i]);
		if (fault == 0)
			for (int i = 63; i >= 0; i--)
				send_bit(link_pkg::CLTU_TAIL[i]);
		for (int i = 0; i < 16; i++)
			send_bit(i[0]);
	endtask : send_cltu
endmodule : ground_station_model

// *** dv/link_coder_sva.sv ***
// Assertions on the link coder top ports
`timescale 1ns/1ps
module link_coder_sva (
	input wire logic               CLK_I,
	input wire logic               SYS_RST_I,
	input wire logic               TX_ON_I,
	input wire logic               PKT_VALID_I,
	input wire logic               PKT_READY_O,
	input wire link_pkg::vc_t      VC_SEL_O,
	input wire logic               FRAME_START_O,
	input wire logic               TX_DATA_O,
	input wire logic               TX_BIT_STB_O,
	input wire link_pkg::cmd_blk_t CMD_O
);
	localparam int MF_BITS = link_pkg::MF_BYTES * 8;
	int   cnt_r;
	logic seen_r;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// Bits since the last frame start; a stopped transmitter clears seen_r, so the next frame start goes unchecked
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cnt_r  <= 0;
			seen_r <= 1'b0;
		end else if (!TX_ON_I) begin
			seen_r <= 1'b0;
		end else if (FRAME_START_O) begin
			cnt_r  <= 1;
			seen_r <= 1'b1;
		end else if (TX_BIT_STB_O) begin
			cnt_r  <= cnt_r + 1;
		end
	end
	property p_frame_len;
		FRAME_START_O && seen_r |-> cnt_r == MF_BITS;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("master frame length wrong");
	property p_fs_stb;
		FRAME_START_O |-> TX_BIT_STB_O && $stable(TX_DATA_O);
	endproperty
	a_fs_stb: assert property (p_fs_stb) else $error("frame start not on a zero marker bit");
	property p_hold;
		!TX_BIT_STB_O |-> $stable(TX_DATA_O);
	endproperty
	a_hold: assert property (p_hold) else $error("line level moved between bits");
	property p_gap;
		TX_BIT_STB_O |=> !TX_BIT_STB_O [*5];
	endproperty
	a_gap: assert property (p_gap) else $error("bit strobes faster than top rate");
	property p_off;
		!TX_ON_I && !$past(TX_ON_I) && !$past(TX_ON_I, 2) |-> !TX_BIT_STB_O;
	endproperty
	a_off: assert property (p_off) else $error("bit sent while transmitter off");
	property p_vc;
		!(VC_SEL_O inside {3'h4, 3'h5, 3'h6});
	endproperty
	a_vc: assert property (p_vc) else $error("unused channel selected");
	property p_flags;
		$onehot0({CMD_O.valid, CMD_O.err, CMD_O.start, CMD_O.stop});
	endproperty
	a_flags: assert property (p_flags) else $error("two uplink flags at once");
	property p_start_gap;
		CMD_O.start |=> !(CMD_O.valid || CMD_O.err || CMD_O.stop) [*8];
	endproperty
	a_start_gap: assert property (p_start_gap) else $error("block result too soon after start");
	property p_full;
		$fell(PKT_READY_O) |-> $past(PKT_VALID_I) || $past(PKT_VALID_I, 2);
	endproperty
	a_full: assert property (p_full) else $error("buffer became full without a push");
	c_frame: cover property (FRAME_START_O && seen_r);
	c_valid: cover property (CMD_O.valid);
	c_err: cover property (CMD_O.err);
	c_full: cover property (!PKT_READY_O);
endmodule : link_coder_sva

bind link_coder link_coder_sva u_sva (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .TX_ON_I(TX_ON_I),
	.PKT_VALID_I(PKT_VALID_I), .PKT_READY_O(PKT_READY_O), .VC_SEL_O(VC_SEL_O), .FRAME_START_O(FRAME_START_O),
	.TX_DATA_O(TX_DATA_O), .TX_BIT_STB_O(TX_BIT_STB_O), .CMD_O(CMD_O));

// *** dv/spacecraft_link_coding_tb_top.sv ***
// Self-checking testbench for the link coder
`timescale 1ns/1ps
module spacecraft_link_coding_tb_top;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               tx_on = 1'b0;
	logic [1:0]         rate_sel = 2'h0;
	logic [3:1]         en_set = 3'h0;
	logic [3:1]         en_clr = 3'h0;
	logic [3:0]         vc_rdy = 4'h0;
	logic [31:0]        status_word = 32'hC1C2C3C4;
	logic [55:0]        tm = 56'h11223344556677;
	logic [7:0]         pkt_d = 8'h00;
	logic               pkt_v = 1'b0;
	logic               pkt_rdy, fs, tx_d, stb, und, cmd_d, dbit, dstb, dfs;
	link_pkg::vc_t      vc_sel;
	link_pkg::cmd_blk_t cmd;
	int error_cnt = 0, checked = 0, n_st = 0, n_ok = 0, n_bad = 0, n_tl = 0, n_und = 0;
	always #20 clk = ~clk;
	link_coder #(.CMD_BIT_CYC(16)) DUT (.CLK_I(clk), .SYS_RST_I(rst), .TX_ON_I(tx_on), .RATE_SEL_I(rate_sel),
		.VC_EN_SET_I(en_set), .VC_EN_CLR_I(en_clr), .VC_RDY_I(vc_rdy), .STATUS_WORD_I(status_word), .TIME_I(tm),
		.PKT_DATA_I(pkt_d), .PKT_VALID_I(pkt_v), .PKT_READY_O(pkt_rdy), .VC_SEL_O(vc_sel), .FRAME_START_O(fs),
		.TX_DATA_O(tx_d), .TX_BIT_STB_O(stb), .UNDERRUN_O(und), .CMD_DATA_I(cmd_d), .CMD_O(cmd));
	ground_station_model #(.BIT_CYC(16)) u_gs (.clk_i(clk), .rst_i(rst), .tx_data_i(tx_d), .tx_stb_i(stb),
		.fs_i(fs), .cmd_data_o(cmd_d), .dec_bit_o(dbit), .dec_stb_o(dstb), .dec_fs_o(dfs));
	// One-cycle flags are counted mid-cycle where they are settled
	always @(negedge clk) begin
		n_st  += int'(cmd.start === 1'b1);
		n_ok  += int'(cmd.valid === 1'b1);
		n_bad += int'(cmd.err === 1'b1);
		n_tl  += int'(cmd.stop === 1'b1);
		n_und += int'(und === 1'b1);
	end
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic t_rate();
		int kb [3] = '{link_pkg::RATE_LO_KBPS, link_pkg::RATE_MID_KBPS, link_pkg::RATE_HI_KBPS};
		int n, e;
		for (int r = 0; r < 3; r++) begin
			rate_sel = 2'(r);
			repeat (2) @(negedge clk);
			tx_on = 1'b1;
			repeat (250) @(negedge clk);
			n = 0;
			repeat (2000) @(negedge clk) n += int'(stb === 1'b1);
			e = 2000 * kb[r] / link_pkg::CLK_KHZ;
			check("bit rate", n >= e - 1 && n <= e + 1, 1'b1);
			tx_on = 1'b0;
		end
	endtask : t_rate
	task automatic t_chan();
		logic [3:1] st [7] = '{3'h0, 3'h0, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0};
		logic [3:1] cl [7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0};
		logic [3:0] rd [7] = '{4'hF, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hF};
		logic [2:0] ex [7] = '{3'h0, 3'h7, 3'h3, 3'h2, 3'h1, 3'h2, 3'h0};
		for (int i = 0; i < 7; i++) begin
			en_set = st[i];
			en_clr = cl[i];
			vc_rdy = rd[i];
			@(negedge clk);
			en_set = 3'h0;
			en_clr = 3'h0;
			repeat (3) @(negedge clk);
			check("channel", vc_sel, ex[i]);
		end
	endtask : t_chan
	task automatic t_frame();
		logic [7:0] fr [link_pkg::MF_BYTES];
		logic [7:0] s;
		logic       b, acc;
		logic [7:0] rt, syn;
		int         n, nb, u0, w;
		rate_sel = 2'h2;
		vc_rdy = 4'h1;
		n = 0;
		for (int k = 0; k < 20; k++) begin
			pkt_d = 8'hA0 + 8'(n);
			pkt_v = 1'b1;
			acc = pkt_rdy;
			@(negedge clk);
			n += int'(acc === 1'b1);
		end
		pkt_v = 1'b0;
		check("buffer depth", n, 16);
		u0 = n_und;
		tx_on = 1'b1;
		w = 0;
		while (dfs !== 1'b1 && w < 1000) begin
			@(negedge clk);
			w++;
		end
		nb = 0;
		s = 8'hFF;
		while (w < 70000) begin
			if (dstb === 1'b1) begin
				if (dfs === 1'b1 && nb > 0)
					break;
				b = dbit;
				if (nb >= 32) begin
					b = b ^ s[7];
					s = {s[6:0], s[7] ^ s[4] ^ s[2] ^ s[0]};
				end
				if (nb < link_pkg::MF_BYTES * 8)
					fr[nb / 8][7 - nb % 8] = b;
				nb++;
			end
			@(negedge clk);
			w++;
		end
		tx_on = 1'b0;
		check("frame bits", nb, link_pkg::MF_BYTES * 8);
		check("marker", {fr[0], fr[1], fr[2], fr[3]}, link_pkg::SYNC_MARKER);
		check("header", {fr[4], fr[5]}, 16'h0001);
		for (int i = 0; i < 7; i++)
			check("time", fr[link_pkg::POS_SEC + i], tm[55 - 8 * i -: 8]);
		for (int i = 0; i < 16; i++)
			check("data", fr[link_pkg::POS_DATA + i], 8'hA0 + 8'(i));
		check("fill", fr[link_pkg::POS_DATA + 16], 8'hBE);
		check("underruns", n_und - u0, link_pkg::DATA_BYTES - 16);
		for (int i = 0; i < 4; i++)
			check("status", fr[link_pkg::POS_TRL + i], status_word[31 - 8 * i -: 8]);
		// Each interleaved codeword must vanish at the first generator root
		rt = 8'h01;
		for (int i = 0; i < 11 * 112; i++)
			rt = gmul(rt, link_pkg::GF_ALPHA);
		for (int c = 0; c < 5; c++) begin
			syn = 8'h00;
			for (int j = 0; j < 255; j++)
				syn = gmul(syn, rt) ^ fr[j < 223 ? link_pkg::POS_TF + 5 * j + c : link_pkg::POS_PAR + 5 * (j - 223) + c];
			check("rs syndrome", syn, 8'h00);
		end
	endtask : t_frame
	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ link_pkg::GF_POLY) : {r[6:0], 1'b0};
			if (b[i])
				r ^= a;
		end
		return r;
	endfunction : gmul
	task automatic t_uplink();
		int s0, v0, e0, p0;
		for (int c = 0; c < 3; c++) begin
			s0 = n_st;
			v0 = n_ok;
			e0 = n_bad;
			p0 = n_tl;
			u_gs.send_cltu(56'h0123456789ABCD + 56'(c), c, 1'(c == 1));
			check("start", n_st - s0, 1);
			check("good", n_ok - v0, c == 0);
			check("bad", n_bad - e0, c != 0);
			check("tail", n_tl - p0, c == 0);
			if (c == 0)
				check("cmd data", cmd.data, 56'h0123456789ABCD);
		end
	endtask : t_uplink
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		check("reset channel", vc_sel, link_pkg::VC_FILL);
		t_rate();
		t_chan();
		t_frame();
		t_uplink();
		wrap_up();
	end
	// Whole run is near 83000 cycles, so this only trips on a hang
	initial begin
		repeat (120000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
endmodule : spacecraft_link_coding_tb_top

// *** src/link_coder.sv ***
// Spacecraft link coder: downlink master framer and uplink CLTU receiver
// Summary of operation
// - Downlink bits leave NRZ-M encoded.
// - Downlink bit rate is 125, 1000 or 4000 kbps.
// - Reset (board power cycle) falls back to 125 kbps.
// - Master frame is 1279 bytes: sync marker, transfer frame, check trailer.
// - Frames follow back to back with no gap.
// - Each frame opens with sync marker 1ACFFC1D, MSB first.
// - RS(255,223) depth 5 adds 160 check bytes.
// - Codeblock, not sync marker, is XORed with x^8+x^7+x^5+x^3+1 sequence.
// - Transfer frame is 6+7+1098+4 = 1115 bytes.
// - One source packet fills each data field.
// - Ready enabled channels served in fixed priority, channels four to six unused.
// - Fill channel seven sends 0xBE pattern when nothing else selected.
// - After transmitter turn-on, frames after the first carry only realtime health and fill.
// - Other channels become eligible only after an enabling command.
// - Uplink bits recovered at 2 kbps.
// - Uplink bits are NRZ-L levels.
// - Acquisition run of either phase is accepted and ignored.
// - Idle alternating runs between units are ignored.
// - CLTU opens with EB90, ends with alternating tail, at most 306 bytes.
// - Codeblock is 56 data, 7 parity, one zero fill bit.
// - Parity is complemented BCH with x^7+x^6+x^2+1.
// - Start and tail unencoded; no derandomizing or decoding on uplink.
// - Transfer frame trailer carries the command link status word.
`timescale 1ns/1ps

module sc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic          not_full;
		logic          not_empty;
	} fifo_st_t;

	fifo_st_t             q;
	fifo_st_t             n;
	logic [WIDTH-1:0]     mem [DEPTH];
	logic                 push;
	logic                 pop;

	assign push        = in_valid_i & q.not_full;
	assign pop         = out_ready_i & q.not_empty;
	assign in_ready_o  = q.not_full;
	assign out_valid_o = q.not_empty;
	assign out_data_o  = mem[q.rp];

	always_comb begin
		n = q;
		if (push)
			n.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
		if (pop)
			n.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
		n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		// Flags registered so both handshake outputs come from flops
		n.not_full  = n.cnt != (AW+1)'(DEPTH);
		n.not_empty = n.cnt != '0;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			q <= '{wp: '0, rp: '0, cnt: '0, not_full: 1'b1, not_empty: 1'b0};
		else
			q <= n;
	end

	always_ff @(posedge clk_i) begin
		if (push)
			mem[q.wp] <= in_data_i;
	end
endmodule : sc_fifo

module link_coder #(
	parameter logic [7:0] FILL_PAT    = 8'hBE,
	// Arbitrary spacecraft id, set per mission
	parameter logic [9:0] SC_ID       = 10'h000,
	parameter int         CMD_BIT_CYC = link_pkg::CMD_BIT_CYC,
	parameter int         FIFO_DEPTH  = 16
) (
	input  wire logic                  CLK_I,
	input  wire logic                  SYS_RST_I,
	input  wire logic                  TX_ON_I,
	input  wire logic [1:0]            RATE_SEL_I,
	input  wire logic [3:1]            VC_EN_SET_I,
	input  wire logic [3:1]            VC_EN_CLR_I,
	input  wire logic [3:0]            VC_RDY_I,
	input  wire logic [31:0]           STATUS_WORD_I,
	input  wire logic [55:0]           TIME_I,
	input  wire logic [7:0]            PKT_DATA_I,
	input  wire logic                  PKT_VALID_I,
	output logic                       PKT_READY_O,
	output link_pkg::vc_t              VC_SEL_O,
	output logic                       FRAME_START_O,
	output logic                       TX_DATA_O,
	output logic                       TX_BIT_STB_O,
	output logic                       UNDERRUN_O,
	input  wire logic                  CMD_DATA_I,
	output link_pkg::cmd_blk_t         CMD_O
);
	localparam int CW = $clog2(CMD_BIT_CYC);
	localparam logic [link_pkg::RS_PAR:0][7:0] RS_GEN = link_pkg::rs_gen();

	typedef struct packed {
		logic                          txon;
		link_pkg::rate_t               rate;
		logic [15:0]                   acc;
		logic [10:0]                   pos;
		logic [2:0]                    bitn;
		logic [7:0]                    sh;
		logic [2:0]                    ilv;
		logic [7:0]                    rnd;
		logic                          lvl;
		logic                          stb;
		logic                          fstart;
		logic                          underrun;
		link_pkg::vc_t                 vc;
		logic [3:1]                    en;
		logic [7:0]                    mcnt;
		logic [4:0][31:0][7:0]         par;
		logic                          s1;
		logic                          s2;
		logic                          prev;
		logic [CW-1:0]                 bcnt;
		logic [63:0]                   sr;
		link_pkg::up_t                 up;
		logic [5:0]                    nb;
		logic [5:0]                    nblk;
		link_pkg::cmd_blk_t            cmd;
	} st_t;

	st_t          q;
	st_t          n;
	logic [7:0]   fifo_data;
	logic         fifo_valid;
	logic         pop;

	function automatic link_pkg::vc_t pick(input logic [3:1] en, input logic [3:0] rdy);
		if (rdy[0])
			return link_pkg::VC_RT_HEALTH;
		else if (en[1] && rdy[1])
			return link_pkg::VC_REC_HEALTH;
		else if (en[2] && rdy[2])
			return link_pkg::VC_RT_SCIENCE;
		else if (en[3] && rdy[3])
			return link_pkg::VC_REC_SCIENCE;
		return link_pkg::VC_FILL;
	endfunction : pick

	function automatic logic [15:0] rate_kbps(input link_pkg::rate_t r);
		unique case (r)
			link_pkg::RATE_MID: return 16'(link_pkg::RATE_MID_KBPS);
			link_pkg::RATE_HI:  return 16'(link_pkg::RATE_HI_KBPS);
			default:            return 16'(link_pkg::RATE_LO_KBPS);
		endcase
	endfunction : rate_kbps

	// Packet bytes buffer here so the source may run ahead of the bit clock
	sc_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (CLK_I),
		.rst_i       (SYS_RST_I),
		.in_data_i   (PKT_DATA_I),
		.in_valid_i  (PKT_VALID_I),
		.in_ready_o  (PKT_READY_O),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (pop)
	);

	always_comb begin
		logic [15:0]       sum;
		logic [10:0]       p;
		logic [7:0]        b;
		logic [7:0]        fb;
		logic              obit;
		logic [2:0]        k;
		logic [63:0]       w;
		logic [47:0]       hdr;
		link_pkg::rate_t   rsel;
		n = q;
		pop = 1'b0;
		sum = '0;
		p = '0;
		b = '0;
		fb = '0;
		obit = 1'b0;
		k = '0;
		w = '0;
		hdr = {link_pkg::PRI_VERSION, SC_ID, q.vc, 1'b1, q.mcnt, 24'h000000};
		rsel = (RATE_SEL_I == link_pkg::RATE_MID || RATE_SEL_I == link_pkg::RATE_HI) ?
			link_pkg::rate_t'(RATE_SEL_I) : link_pkg::RATE_LO;
		n.stb = 1'b0;
		n.fstart = 1'b0;
		n.underrun = 1'b0;
		n.cmd.valid = 1'b0;
		n.cmd.err = 1'b0;
		n.cmd.start = 1'b0;
		n.cmd.stop = 1'b0;
		n.txon = TX_ON_I;

		// Set wins over clear when both commands land together
		n.en = (q.en & ~VC_EN_CLR_I) | VC_EN_SET_I;
		if (TX_ON_I && !q.txon)
			n.en = VC_EN_SET_I;

		if (!TX_ON_I) begin
			n.pos = '0;
			n.bitn = '0;
			n.acc = '0;
			n.ilv = '0;
			n.par = '0;
			n.sh = link_pkg::SYNC_MARKER[31:24];
			n.vc = pick(q.en, VC_RDY_I);
			n.rate = rsel;
		end else begin
			// Fractional divider gives an exact average rate at 4000 kbps
			sum = q.acc + rate_kbps(q.rate);
			n.acc = sum;
			if (sum >= 16'(link_pkg::CLK_KHZ)) begin
				n.acc = sum - 16'(link_pkg::CLK_KHZ);
				n.stb = 1'b1;
				n.fstart = (q.pos == '0) && (q.bitn == '0);
				obit = q.sh[7];
				if (q.pos >= 11'(link_pkg::POS_TF)) begin
					obit = q.sh[7] ^ q.rnd[7];
					n.rnd = {q.rnd[6:0], ^(q.rnd & link_pkg::RAND_TAPS)};
				end
				n.lvl = q.lvl ^ obit;
				n.sh = {q.sh[6:0], 1'b0};
				n.bitn = q.bitn + 3'd1;
				if (q.bitn == 3'd7) begin
					// Wrap straight into the next frame's marker
					p = (q.pos == 11'(link_pkg::MF_BYTES - 1)) ? '0 : q.pos + 11'd1;
					n.pos = p;
					k = (p == 11'(link_pkg::POS_TF) || q.ilv == 3'(link_pkg::RS_DEPTH - 1)) ?
						'0 : q.ilv + 3'd1;
					n.ilv = k;
					if (p < 11'(link_pkg::POS_TF)) begin
						b = link_pkg::SYNC_MARKER[8*(link_pkg::SYNC_BYTES-1-int'(p)) +: 8];
						if (p == '0) begin
							n.vc = pick(q.en, VC_RDY_I);
							n.mcnt = q.mcnt + 8'd1;
							n.rate = rsel;
						end
					end else if (p < 11'(link_pkg::POS_SEC)) begin
						b = hdr[8*(link_pkg::POS_SEC-1-int'(p)) +: 8];
					end else if (p < 11'(link_pkg::POS_DATA)) begin
						b = TIME_I[8*(link_pkg::POS_DATA-1-int'(p)) +: 8];
					end else if (p < 11'(link_pkg::POS_TRL)) begin
						b = FILL_PAT;
						if (q.vc != link_pkg::VC_FILL) begin
							// A starved source is patched with fill, never a gap
							if (fifo_valid) begin
								b = fifo_data;
								pop = 1'b1;
							end else begin
								n.underrun = 1'b1;
							end
						end
					end else if (p < 11'(link_pkg::POS_PAR)) begin
						b = STATUS_WORD_I[8*(link_pkg::POS_PAR-1-int'(p)) +: 8];
					end
					if (p >= 11'(link_pkg::POS_TF) && p < 11'(link_pkg::POS_PAR)) begin
						fb = b ^ q.par[k][link_pkg::RS_PAR-1];
						for (int i = 0; i < link_pkg::RS_PAR; i++)
							n.par[k][i] = (i == 0 ? 8'h00 : q.par[k][i-1]) ^ link_pkg::gf_mul(fb, RS_GEN[i]);
					end else if (p >= 11'(link_pkg::POS_PAR)) begin
						b = q.par[k][link_pkg::RS_PAR-1];
						n.par[k] = {q.par[k][link_pkg::RS_PAR-2:0], 8'h00};
					end
					if (p == 11'(link_pkg::POS_TF))
						n.rnd = link_pkg::RAND_SEED;
					n.sh = b;
				end
			end
		end

		// Uplink: two-flop sync, then a bit timer realigned on every edge
		n.s1 = CMD_DATA_I;
		n.s2 = q.s1;
		n.prev = q.s2;
		if (q.s2 != q.prev) begin
			n.bcnt = CW'(CMD_BIT_CYC / 2);
		end else if (q.bcnt == '0) begin
			n.bcnt = CW'(CMD_BIT_CYC - 1);
			w = {q.sr[62:0], q.s2};
			n.sr = w;
			unique case (q.up)
				link_pkg::UP_HUNT: begin
					// Alternating runs of either phase never match the start word
					if (w[15:0] == link_pkg::CLTU_START) begin
						n.up = link_pkg::UP_BLOCK;
						n.nb = '0;
						n.nblk = '0;
						n.cmd.start = 1'b1;
					end
				end
				link_pkg::UP_BLOCK: begin
					n.nb = q.nb + 6'd1;
					if (q.nb == 6'(link_pkg::CB_BITS - 1)) begin
						n.nb = '0;
						if (w == link_pkg::CLTU_TAIL) begin
							n.cmd.stop = 1'b1;
							n.up = link_pkg::UP_HUNT;
						end else if (w[7:1] == ~link_pkg::bch_parity(w[63:8]) && !w[0]
								&& q.nblk < 6'(link_pkg::CLTU_MAX_BLKS)) begin
							n.cmd.valid = 1'b1;
							n.cmd.data = w[63:8];
							n.nblk = q.nblk + 6'd1;
						end else begin
							n.cmd.err = 1'b1;
							n.up = link_pkg::UP_HUNT;
						end
					end
				end
			endcase
		end else begin
			n.bcnt = q.bcnt - 1'b1;
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			q <= '0;
			q.rate <= link_pkg::RATE_LO;
			q.vc <= link_pkg::VC_FILL;
			q.sh <= link_pkg::SYNC_MARKER[31:24];
			q.rnd <= link_pkg::RAND_SEED;
			q.up <= link_pkg::UP_HUNT;
		end else begin
			q <= n;
		end
	end

	assign VC_SEL_O      = q.vc;
	assign FRAME_START_O = q.fstart;
	assign TX_DATA_O     = q.lvl;
	assign TX_BIT_STB_O  = q.stb;
	assign UNDERRUN_O    = q.underrun;
	assign CMD_O         = q.cmd;
endmodule : link_coder

// *** src/link_pkg.sv ***
// Shared constants, types and coding functions for the spacecraft link coder
package link_pkg;
	localparam int CLK_KHZ       = 25000;
	localparam int RATE_LO_KBPS  = 125;
	localparam int RATE_MID_KBPS = 1000;
	localparam int RATE_HI_KBPS  = 4000;
	localparam int CMD_KBPS      = 2;
	localparam int CMD_BIT_CYC   = CLK_KHZ / CMD_KBPS;

	localparam logic [31:0] SYNC_MARKER = 32'h1ACFFC1D;
	localparam int SYNC_BYTES  = 4;
	localparam int PRI_BYTES   = 6;
	localparam int SEC_BYTES   = 7;
	localparam int DATA_BYTES  = 1098;
	localparam int TRL_BYTES   = 4;
	localparam int RS_DEPTH    = 5;
	localparam int RS_PAR      = 32;
	localparam int POS_TF      = SYNC_BYTES;
	localparam int POS_SEC     = POS_TF + PRI_BYTES;
	localparam int POS_DATA    = POS_SEC + SEC_BYTES;
	localparam int POS_TRL     = POS_DATA + DATA_BYTES;
	localparam int POS_PAR     = POS_TRL + TRL_BYTES;
	localparam int MF_BYTES    = POS_PAR + RS_DEPTH * RS_PAR;

	localparam logic [7:0] RAND_SEED = 8'hFF;
	localparam logic [7:0] RAND_TAPS = 8'h95;
	localparam logic [7:0] GF_POLY   = 8'h87;
	localparam logic [7:0] GF_ONE    = 8'h01;
	localparam logic [7:0] GF_ALPHA  = 8'h02;
	localparam int RS_ROOT_STEP  = 11;
	localparam int RS_FIRST_ROOT = 112;
	localparam logic [1:0] PRI_VERSION = 2'h0;

	localparam logic [15:0] CLTU_START = 16'hEB90;
	localparam logic [63:0] CLTU_TAIL  = 64'h5555555555555555;
	localparam logic [6:0]  BCH_POLY   = 7'h45;
	localparam int CB_BITS        = 64;
	localparam int CB_DATA_BITS   = 56;
	localparam int CLTU_MAX_BYTES = 306;
	localparam int CLTU_MAX_BLKS  = (CLTU_MAX_BYTES - 2 - CB_BITS / 8) / (CB_BITS / 8);

	typedef enum logic [2:0] {
		VC_RT_HEALTH  = 3'b000,
		VC_REC_HEALTH = 3'b001,
		VC_RT_SCIENCE = 3'b010,
		VC_REC_SCIENCE = 3'b011,
		VC_FILL       = 3'b111
	} vc_t;

	typedef enum logic [1:0] {
		RATE_LO  = 2'b00,
		RATE_MID = 2'b01,
		RATE_HI  = 2'b10
	} rate_t;

	typedef enum logic [0:0] {
		UP_HUNT  = 1'b0,
		UP_BLOCK = 1'b1
	} up_t;

	typedef struct packed {
		logic [CB_DATA_BITS-1:0] data;
		logic                    valid;
		logic                    err;
		logic                    start;
		logic                    stop;
	} cmd_blk_t;

	function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] r;
		logic [7:0] x;
		r = '0;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i])
				r ^= x;
			x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY) : {x[6:0], 1'b0};
		end
		return r;
	endfunction : gf_mul

	// Generator built at elaboration so no coefficient table has to be typed in
	function automatic logic [RS_PAR:0][7:0] rs_gen();
		logic [RS_PAR:0][7:0] g;
		logic [7:0] step;
		logic [7:0] root;
		g = '0;
		g[0] = GF_ONE;
		step = GF_ONE;
		for (int i = 0; i < RS_ROOT_STEP; i++)
			step = gf_mul(step, GF_ALPHA);
		root = GF_ONE;
		for (int i = 0; i < RS_FIRST_ROOT; i++)
			root = gf_mul(root, step);
		for (int j = 0; j < RS_PAR; j++) begin
			for (int i = RS_PAR; i > 0; i--)
				g[i] = g[i-1] ^ gf_mul(g[i], root);
			g[0] = gf_mul(g[0], root);
			root = gf_mul(root, step);
		end
		return g;
	endfunction : rs_gen

	function automatic logic [6:0] bch_parity(input logic [CB_DATA_BITS-1:0] d);
		logic [6:0] r;
		logic       fb;
		r = '0;
		for (int i = CB_DATA_BITS - 1; i >= 0; i--) begin
			fb = d[i] ^ r[6];
			r = {r[5:0], 1'b0} ^ (fb ? BCH_POLY : 7'h00);
		end
		return r;
	endfunction : bch_parity
endpackage : link_pkg
